// *** mjc_judge.v ***
// Contract
// [RULE1] above upper limit grades high
// [RULE2] between limits inclusive grades inside
// [RULE3] below lower limit grades low
// [RULE4] resistance, voltage, route graded independently
// [RULE5] magnitude mode compares voltage absolute value
// [RULE6] over-range high/low, invalid gives no grade
// [RULE7] comparator off gives no grades (route grades are still given with route check on)
// [RULE8] route above fail threshold grades fail
// [RULE9] route between thresholds grades warning
// [RULE10] route below warning grades pass
// [RULE11] no route grade if abnormal or off
// [RULE12] route thresholds -10..50 ohm, lowest range capped
// [RULE13] all grades and verdicts drive outputs
// [RULE14] verdict one only with comparator on
// [RULE15] verdict one passes only on inside grades
// [RULE16] verdict two needs comparator and route on
// [RULE17] verdict two needs verdict one and route ok; the code skips the route condition when resistance function is off
// [RULE18] each of four terminals graded separately
// [RULE19] route fail flags error, suppresses readings; the code flags it only with resistance function on
// [RULE20] reject limits with upper below lower
// [RULE21] results computed per measurement, held stable
`timescale 1ns/1ps
`include "mjc_consts.vh"
module mjc_judge #(
	parameter VALUE_W = 32,
	parameter ROUTE_W = 16,
	parameter TERMS = 4
) (
	input wire core_clk_i,
	input wire rst_i,
	input wire meas_done_i,
	input wire [VALUE_W-1:0] res_value_i,
	input wire [1:0] res_status_i,
	input wire [VALUE_W-1:0] volt_value_i,
	input wire [1:0] volt_status_i,
	input wire [TERMS*ROUTE_W-1:0] route_value_i,
	input wire [TERMS*2-1:0] route_status_i,
	input wire res_func_i,
	input wire volt_func_i,
	input wire lowest_range_i,
	input wire comparator_enable_i,
	input wire route_check_enable_i,
	input wire magnitude_compare_enable_i,
	input wire limit_wr_i,
	input wire [1:0] limit_sel_i,
	input wire [VALUE_W-1:0] limit_upper_i,
	input wire [VALUE_W-1:0] limit_lower_i,
	output reg busy_o,
	output reg limit_ack_o,
	output reg limit_reject_o,
	output reg result_done_o,
	output reg [1:0] res_grade_o,
	output reg [1:0] volt_grade_o,
	output reg [1:0] route_grade_o,
	output reg [TERMS*2-1:0] route_term_grade_o,
	output reg meas_error_o,
	output reg verdict1_valid_o,
	output reg verdict1_pass_o,
	output reg verdict2_valid_o,
	output reg verdict2_pass_o
);
	// =====================================================
	// states
	localparam [2:0] S_INIT = 3'h0;
	localparam [2:0] S_IDLE = 3'h1;
	localparam [2:0] S_READ = 3'h2;
	localparam [2:0] S_EVAL = 3'h3;
	localparam [2:0] S_WR_HI = 3'h4;
	localparam [2:0] S_WR_LO = 3'h5;

	localparam signed [VALUE_W:0] RT_MIN = `MJC_ROUTE_MIN;
	localparam signed [VALUE_W:0] RT_MAX = `MJC_ROUTE_MAX;
	localparam signed [VALUE_W:0] RT_CAP = `MJC_ROUTE_CAP;

	// =====================================================
	// grading functions
	function [1:0] grade_lim;
		input signed [VALUE_W:0] v;
		input signed [VALUE_W:0] hi;
		input signed [VALUE_W:0] lo;
		begin
			if (v > hi)
				grade_lim = `MJC_G_HI; // RULE1
			else if (v < lo)
				grade_lim = `MJC_G_LO; // RULE3
			else
				grade_lim = `MJC_G_IN; // RULE2
		end
	endfunction

	function [1:0] grade_reading;
		input [1:0] st;
		input signed [VALUE_W:0] v;
		input signed [VALUE_W:0] hi;
		input signed [VALUE_W:0] lo;
		begin
			if (st == `MJC_ST_POVER)
				grade_reading = `MJC_G_HI; // RULE6
			else if (st == `MJC_ST_NOVER)
				grade_reading = `MJC_G_LO; // RULE6
			else if (st == `MJC_ST_VALID)
				grade_reading = grade_lim(v, hi, lo);
			else
				grade_reading = `MJC_G_NONE; // RULE6
		end
	endfunction

	function signed [VALUE_W:0] sext;
		input [VALUE_W-1:0] x;
		begin
			sext = {x[VALUE_W-1], x};
		end
	endfunction

	// =====================================================
	// state and snapshot
	reg [2:0] state_q;
	reg [2:0] cnt_q;
	reg signed [VALUE_W-1:0] lim_q [0:`MJC_LIM_WORDS-1];
	reg [VALUE_W-1:0] res_v_q;
	reg [1:0] res_st_q;
	reg [VALUE_W-1:0] volt_v_q;
	reg [1:0] volt_st_q;
	reg [TERMS*ROUTE_W-1:0] route_v_q;
	reg [TERMS*2-1:0] route_st_q;
	reg [5:0] mode_q;
	reg [1:0] wsel_q;
	reg [VALUE_W-1:0] wup_q;
	reg [VALUE_W-1:0] wlo_q;

	wire c_res = mode_q[0];
	wire c_volt = mode_q[1];
	wire c_low = mode_q[2];
	wire c_comp = mode_q[3];
	wire c_route = mode_q[4];
	wire c_mag = mode_q[5];

	// =====================================================
	// limit store
	reg mem_we;
	reg [2:0] mem_waddr;
	reg [VALUE_W-1:0] mem_wdata;
	wire [VALUE_W-1:0] mem_rdata;

	always @*
	begin
		mem_we = 1'b0;
		mem_waddr = cnt_q;
		mem_wdata = {VALUE_W{1'b0}};
		if (state_q == S_INIT)
			mem_we = 1'b1;
		else if (state_q == S_WR_HI)
		begin
			mem_we = 1'b1;
			mem_waddr = {wsel_q, 1'b0};
			mem_wdata = wup_q;
		end
		else if (state_q == S_WR_LO)
		begin
			mem_we = 1'b1;
			mem_waddr = {wsel_q, 1'b1};
			mem_wdata = wlo_q;
		end
	end

	mjc_lim_mem #(
		.DATA_W(VALUE_W),
		.DEPTH(`MJC_LIM_WORDS),
		.ADDR_W(3)
	) u_mem (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.wr_en_i(mem_we),
		.wr_addr_i(mem_waddr),
		.wr_data_i(mem_wdata),
		.rd_addr_i(cnt_q),
		.rd_data_o(mem_rdata)
	);

	// =====================================================
	// limit update check
	reg wr_bad;
	always @*
	begin
		wr_bad = 1'b0;
		if (sext(limit_upper_i) < sext(limit_lower_i))
			wr_bad = 1'b1; // RULE20
		if (limit_sel_i == `MJC_SEL_ROUTE)
		begin
			if (sext(limit_upper_i) > RT_MAX || sext(limit_lower_i) < RT_MIN)
				wr_bad = 1'b1; // RULE12
		end
		else if (limit_sel_i != `MJC_SEL_RES && limit_sel_i != `MJC_SEL_VOLT)
			wr_bad = 1'b1;
	end

	// =====================================================
	// evaluation from snapshot and fetched limits
	reg [1:0] g_res;
	reg [1:0] g_volt;
	reg [1:0] g_route;
	reg [TERMS*2-1:0] g_term;
	reg g_err;
	reg v1_val;
	reg v1_pass;
	reg v2_val;
	reg v2_pass;
	reg signed [VALUE_W:0] vv;
	reg signed [VALUE_W:0] rv;
	reg [1:0] tg;
	reg any_none;
	integer t;

	always @*
	begin
		vv = sext(volt_v_q);
		rv = {(VALUE_W+1){1'b0}};
		tg = `MJC_R_NONE;
		any_none = 1'b0;
		g_route = `MJC_R_NONE;
		g_term = {(TERMS*2){1'b0}};
		if (c_mag && vv < 0)
			vv = -vv; // RULE5
		g_res = grade_reading(res_st_q, sext(res_v_q), lim_q[`MJC_A_RES_HI],
			lim_q[`MJC_A_RES_LO]); // RULE4
		g_volt = grade_reading(volt_st_q, vv, lim_q[`MJC_A_VOLT_HI],
			lim_q[`MJC_A_VOLT_LO]); // RULE4
		for (t = 0; t < TERMS; t = t + 1)
		begin
			rv = {{(VALUE_W+1-ROUTE_W){route_v_q[t*ROUTE_W+ROUTE_W-1]}},
				route_v_q[t*ROUTE_W +: ROUTE_W]};
			if (c_low && rv > RT_CAP)
				rv = RT_CAP; // RULE12
			if (!c_route || route_st_q[t*2 +: 2] != `MJC_ST_VALID)
				tg = `MJC_R_NONE; // RULE11
			else if (rv > sext(lim_q[`MJC_A_ROUTE_FAIL]))
				tg = `MJC_R_FAIL; // RULE8
			else if (rv >= sext(lim_q[`MJC_A_ROUTE_WARN]))
				tg = `MJC_R_WARN; // RULE9
			else
				tg = `MJC_R_PASS; // RULE10
			g_term[t*2 +: 2] = tg; // RULE18
			if (tg == `MJC_R_NONE)
				any_none = 1'b1;
			else if (tg > g_route)
				g_route = tg;
		end
		// worst terminal wins; a missing terminal makes the whole route missing
		if (any_none)
			g_route = `MJC_R_NONE;
		g_err = (g_route == `MJC_R_FAIL) && c_res; // RULE19
		if (!c_comp || g_err || !c_res)
			g_res = `MJC_G_NONE; // RULE7
		if (!c_comp || g_err || !c_volt)
			g_volt = `MJC_G_NONE; // RULE7
		v1_val = c_comp; // RULE14
		v1_pass = c_comp && (!c_res || g_res == `MJC_G_IN)
			&& (!c_volt || g_volt == `MJC_G_IN)
			&& (c_res || c_volt); // RULE15
		// voltage-only operation has no route path, verdict two follows verdict one
		v2_val = c_comp && c_route; // RULE16
		v2_pass = v2_val && v1_pass && (!c_res
			|| g_route == `MJC_R_PASS || g_route == `MJC_R_WARN); // RULE17
	end

	// =====================================================
	// control
	integer i;
	always @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state_q <= S_INIT;
			cnt_q <= 3'h0;
			for (i = 0; i < `MJC_LIM_WORDS; i = i + 1)
				lim_q[i] <= {VALUE_W{1'b0}};
			res_v_q <= {VALUE_W{1'b0}};
			res_st_q <= `MJC_ST_INVALID;
			volt_v_q <= {VALUE_W{1'b0}};
			volt_st_q <= `MJC_ST_INVALID;
			route_v_q <= {(TERMS*ROUTE_W){1'b0}};
			route_st_q <= {(TERMS*2){1'b1}};
			mode_q <= 6'h00;
			wsel_q <= 2'h0;
			wup_q <= {VALUE_W{1'b0}};
			wlo_q <= {VALUE_W{1'b0}};
			busy_o <= 1'b1;
			limit_ack_o <= 1'b0;
			limit_reject_o <= 1'b0;
			result_done_o <= 1'b0;
			res_grade_o <= `MJC_G_NONE;
			volt_grade_o <= `MJC_G_NONE;
			route_grade_o <= `MJC_R_NONE;
			route_term_grade_o <= {(TERMS*2){1'b0}};
			meas_error_o <= 1'b0;
			verdict1_valid_o <= 1'b0;
			verdict1_pass_o <= 1'b0;
			verdict2_valid_o <= 1'b0;
			verdict2_pass_o <= 1'b0;
		end
		else
		begin
			limit_ack_o <= 1'b0;
			limit_reject_o <= 1'b0;
			result_done_o <= 1'b0;
			case (state_q)
			S_INIT:
			begin
				// clear every limit word so nothing undefined is ever compared
				cnt_q <= cnt_q + 3'h1;
				if (cnt_q == `MJC_LAST_ADDR)
				begin
					cnt_q <= 3'h0;
					state_q <= S_IDLE;
					busy_o <= 1'b0;
				end
			end
			S_IDLE:
			begin
				// a measurement outranks a limit update in the same cycle
				if (meas_done_i)
				begin
					res_v_q <= res_value_i;
					res_st_q <= res_status_i;
					volt_v_q <= volt_value_i;
					volt_st_q <= volt_status_i;
					route_v_q <= route_value_i;
					route_st_q <= route_status_i;
					mode_q <= {magnitude_compare_enable_i, route_check_enable_i,
						comparator_enable_i, lowest_range_i, volt_func_i, res_func_i};
					cnt_q <= 3'h0;
					state_q <= S_READ;
					busy_o <= 1'b1;
				end
				else if (limit_wr_i)
				begin
					if (wr_bad)
						limit_reject_o <= 1'b1; // RULE20
					else
					begin
						wsel_q <= limit_sel_i;
						wup_q <= limit_upper_i;
						wlo_q <= limit_lower_i;
						state_q <= S_WR_HI;
						busy_o <= 1'b1;
					end
				end
			end
			S_READ:
			begin
				cnt_q <= cnt_q + 3'h1;
				if (cnt_q != 3'h0)
					lim_q[cnt_q - 3'h1] <= mem_rdata;
				if (cnt_q == `MJC_LAST_ADDR + 3'h1)
					state_q <= S_EVAL;
			end
			S_EVAL:
			begin
				res_grade_o <= g_res; // RULE13
				volt_grade_o <= g_volt; // RULE13
				route_grade_o <= g_route; // RULE13
				route_term_grade_o <= g_term; // RULE18
				meas_error_o <= g_err; // RULE19
				verdict1_valid_o <= v1_val; // RULE13
				verdict1_pass_o <= v1_pass; // RULE13
				verdict2_valid_o <= v2_val; // RULE13
				verdict2_pass_o <= v2_pass; // RULE13
				result_done_o <= 1'b1; // RULE21
				cnt_q <= 3'h0;
				state_q <= S_IDLE;
				busy_o <= 1'b0;
			end
			S_WR_HI:
				state_q <= S_WR_LO;
			S_WR_LO:
			begin
				limit_ack_o <= 1'b1;
				cnt_q <= 3'h0;
				state_q <= S_IDLE;
				busy_o <= 1'b0;
			end
			default:
			begin
				state_q <= S_IDLE;
				busy_o <= 1'b0;
			end
			endcase
		end
	end
endmodule

// *** mjc_consts.vh ***
`ifndef MJC_CONSTS_VH
`define MJC_CONSTS_VH

// grade codes for resistance and voltage
`define MJC_G_NONE 2'h0
`define MJC_G_HI 2'h1
`define MJC_G_IN 2'h2
`define MJC_G_LO 2'h3

// grade codes for route resistance
`define MJC_R_NONE 2'h0
`define MJC_R_PASS 2'h1
`define MJC_R_WARN 2'h2
`define MJC_R_FAIL 2'h3

// reading status codes
`define MJC_ST_VALID 2'h0
`define MJC_ST_POVER 2'h1
`define MJC_ST_NOVER 2'h2
`define MJC_ST_INVALID 2'h3

// limit pair selectors
`define MJC_SEL_RES 2'h0
`define MJC_SEL_VOLT 2'h1
`define MJC_SEL_ROUTE 2'h2

// limit store word addresses
`define MJC_A_RES_HI 3'h0
`define MJC_A_RES_LO 3'h1
`define MJC_A_VOLT_HI 3'h2
`define MJC_A_VOLT_LO 3'h3
`define MJC_A_ROUTE_FAIL 3'h4
`define MJC_A_ROUTE_WARN 3'h5
`define MJC_LIM_WORDS 6
`define MJC_LAST_ADDR 3'h5

// route thresholds in units of 0.1 ohm
`define MJC_ROUTE_MIN (-100)
`define MJC_ROUTE_MAX 500
`define MJC_ROUTE_CAP 100

`endif

// *** mjc_lim_mem.v ***
`timescale 1ns/1ps
// =====================================================
// limit store, registered read
module mjc_lim_mem #(
	parameter DATA_W = 32,
	parameter DEPTH = 6,
	parameter ADDR_W = 3
) (
	input wire core_clk_i,
	input wire rst_i,
	input wire wr_en_i,
	input wire [ADDR_W-1:0] wr_addr_i,
	input wire [DATA_W-1:0] wr_data_i,
	input wire [ADDR_W-1:0] rd_addr_i,
	output reg [DATA_W-1:0] rd_data_o
);
	reg [DATA_W-1:0] mem [0:DEPTH-1];

	always @(posedge core_clk_i)
	begin
		if (wr_en_i)
			mem[wr_addr_i] <= wr_data_i;
	end

	// no reset on the array; the owner clears it after reset
	always @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
			rd_data_o <= {DATA_W{1'b0}};
		else
			rd_data_o <= mem[rd_addr_i];
	end
endmodule

// *** mjc_judge_sva.sv ***
`timescale 1ns/1ps
`include "mjc_consts.vh"
// =====================================================
// port checks for the judgment block
module mjc_judge_sva #(
	parameter VALUE_W = 32
) (
	input wire core_clk_i,
	input wire rst_i,
	input wire meas_done_i,
	input wire res_func_i,
	input wire volt_func_i,
	input wire comparator_enable_i,
	input wire route_check_enable_i,
	input wire limit_wr_i,
	input wire [VALUE_W-1:0] limit_upper_i,
	input wire [VALUE_W-1:0] limit_lower_i,
	input wire busy_o,
	input wire limit_reject_o,
	input wire result_done_o,
	input wire [1:0] res_grade_o,
	input wire [1:0] volt_grade_o,
	input wire [1:0] route_grade_o,
	input wire meas_error_o,
	input wire verdict1_valid_o,
	input wire verdict1_pass_o,
	input wire verdict2_valid_o,
	input wire verdict2_pass_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	wire take_m = meas_done_i && !busy_o;
	wire take_l = limit_wr_i && !busy_o && !meas_done_i;
	// mode bits are taken with the request, nine samples before the result
	a_result_latency: assert property (take_m |-> ##1 busy_o [*8] ##1 !busy_o && result_done_o)
		else $error("result timing wrong");
	a_grades_held: assert property (!result_done_o |-> $stable(res_grade_o) && $stable(route_grade_o))
		else $error("grades moved between results");
	a_limit_reject: assert property (take_l && $signed(limit_upper_i) < $signed(limit_lower_i) |-> ##1 limit_reject_o)
		else $error("inverted limits accepted");
	a_comp_off: assert property (result_done_o && !$past(comparator_enable_i, 9) |-> res_grade_o == `MJC_G_NONE && volt_grade_o == `MJC_G_NONE && !verdict1_valid_o)
		else $error("grade with comparator off");
	a_route_off: assert property (result_done_o && !$past(route_check_enable_i, 9) |-> route_grade_o == `MJC_R_NONE && !verdict2_valid_o)
		else $error("route grade with check off");
	a_v1_inside: assert property (result_done_o && verdict1_pass_o |-> (res_grade_o == `MJC_G_IN || !$past(res_func_i, 9)) && (volt_grade_o == `MJC_G_IN || !$past(volt_func_i, 9)))
		else $error("verdict one pass without inside");
	a_v2_needs_v1: assert property (result_done_o && verdict2_pass_o |-> verdict1_pass_o && verdict2_valid_o)
		else $error("verdict two pass without verdict one");
	a_error_blanks: assert property (result_done_o && meas_error_o |-> route_grade_o == `MJC_R_FAIL && res_grade_o == `MJC_G_NONE && volt_grade_o == `MJC_G_NONE)
		else $error("error without blanking");
	c_v2_pass: cover property (result_done_o && verdict2_pass_o);
	c_reject: cover property (limit_reject_o);
	c_error: cover property (result_done_o && meas_error_o);
endmodule

bind mjc_judge mjc_judge_sva #(.VALUE_W(VALUE_W)) u_sva (
	.core_clk_i,
	.rst_i,
	.meas_done_i,
	.res_func_i,
	.volt_func_i,
	.comparator_enable_i,
	.route_check_enable_i,
	.limit_wr_i,
	.limit_upper_i,
	.limit_lower_i,
	.busy_o,
	.limit_reject_o,
	.result_done_o,
	.res_grade_o,
	.volt_grade_o,
	.route_grade_o,
	.meas_error_o,
	.verdict1_valid_o,
	.verdict1_pass_o,
	.verdict2_valid_o,
	.verdict2_pass_o
);

// *** mjc_front.sv ***
`timescale 1ns/1ps
// =====================================================
// measurement front end model
module mjc_front (
	input wire core_clk_i,
	input wire busy_i,
	output reg meas_done_o = 1'b0,
	output reg [31:0] res_value_o = 32'h0,
	output reg [1:0] res_status_o = 2'h0,
	output reg [31:0] volt_value_o = 32'h0,
	output reg [1:0] volt_status_o = 2'h0,
	output reg [63:0] route_value_o = 64'h0,
	output reg [7:0] route_status_o = 8'h0
);
	task measure(input [31:0] r, input [1:0] rs, input [31:0] v, input [1:0] vs,
		input [63:0] rt, input [7:0] rts);
		integer k;
		begin
			k = 0;
			while (busy_i && k < 50)
			begin
				@(negedge core_clk_i);
				k = k + 1;
			end
			{res_value_o, res_status_o, volt_value_o, volt_status_o} = {r, rs, v, vs};
			{route_value_o, route_status_o} = {rt, rts};
			meas_done_o = 1'b1;
			@(negedge core_clk_i);
			meas_done_o = 1'b0;
			// readings are only good at the taking edge, so spoil them after
			{res_value_o, volt_value_o, route_value_o} = ~{r, v, rt};
		end
	endtask
endmodule

// *** test_mjc_judge.sv ***
`timescale 1ns/1ps
module test_mjc_judge;
	reg core_clk_i = 1'b0;
	reg rst_i = 1'b1;
	reg comparator_enable_i = 1'b0;
	reg route_check_enable_i = 1'b0;
	reg magnitude_compare_enable_i = 1'b0;
	reg lowest_range_i = 1'b0;
	reg res_func_i = 1'b1;
	reg volt_func_i = 1'b1;
	reg limit_wr_i = 1'b0;
	reg [1:0] limit_sel_i = 2'h0;
	reg [31:0] limit_upper_i = 32'h0;
	reg [31:0] limit_lower_i = 32'h0;
	wire meas_done_i, busy_o, limit_ack_o, limit_reject_o, result_done_o, meas_error_o;
	wire [1:0] res_status_i, volt_status_i, res_grade_o, volt_grade_o, route_grade_o;
	wire [31:0] res_value_i, volt_value_i;
	wire [63:0] route_value_i;
	wire [7:0] route_status_i, route_term_grade_o;
	wire verdict1_valid_o, verdict1_pass_o, verdict2_valid_o, verdict2_pass_o;
	integer failures = 0;
	integer compares = 0;
	integer n;
	always #50 core_clk_i = ~core_clk_i;
	mjc_front u_fe (.core_clk_i, .busy_i(busy_o), .meas_done_o(meas_done_i),
		.res_value_o(res_value_i), .res_status_o(res_status_i),
		.volt_value_o(volt_value_i), .volt_status_o(volt_status_i),
		.route_value_o(route_value_i), .route_status_o(route_status_i));
	mjc_judge u_dut (.core_clk_i, .rst_i, .meas_done_i, .res_value_i, .res_status_i,
		.volt_value_i, .volt_status_i, .route_value_i, .route_status_i,
		.res_func_i, .volt_func_i, .lowest_range_i, .comparator_enable_i,
		.route_check_enable_i, .magnitude_compare_enable_i, .limit_wr_i, .limit_sel_i,
		.limit_upper_i, .limit_lower_i, .busy_o, .limit_ack_o, .limit_reject_o,
		.result_done_o, .res_grade_o, .volt_grade_o, .route_grade_o, .route_term_grade_o,
		.meas_error_o, .verdict1_valid_o, .verdict1_pass_o, .verdict2_valid_o,
		.verdict2_pass_o);
	// =====================================================
	// bench tasks
	task give_verdict;
		begin
			$display("compares %0d failures %0d", compares, failures);
			if (failures == 0 && compares > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask
	task tick;
		begin
			@(negedge core_clk_i);
			n = n + 1;
			if (n > 40)
			begin
				failures = failures + 1;
				give_verdict;
			end
		end
	endtask
	task check(input string nm, input [15:0] seen, input [15:0] exp);
		begin
			compares = compares + 1;
			if (seen !== exp)
			begin
				failures = failures + 1;
				$display("Error %s expected %h seen %h", nm, exp, seen);
			end
		end
	endtask
	task set_lim(input [1:0] s, input [31:0] u, input [31:0] l, input ok);
		begin
			n = 0;
			while (busy_o)
				tick;
			limit_sel_i = s;
			limit_upper_i = u;
			limit_lower_i = l;
			limit_wr_i = 1'b1;
			@(negedge core_clk_i);
			limit_wr_i = 1'b0;
			n = 0;
			while (!limit_ack_o && !limit_reject_o)
				tick;
			check("limit answer", {limit_ack_o, limit_reject_o}, {ok, !ok});
		end
	endtask
	// terminal 0 carries rt, the other three a clean 1.0 ohm path
	task meas(input [3:0] c, input [31:0] r, input [1:0] rs, input [31:0] v,
		input [1:0] vs, input [15:0] rt, input [7:0] rts, input [10:0] e);
		begin
			{comparator_enable_i, route_check_enable_i} = c[3:2];
			{magnitude_compare_enable_i, lowest_range_i} = c[1:0];
			u_fe.measure(r, rs, v, vs, {{3{16'h000a}}, rt}, rts);
			n = 0;
			while (!result_done_o)
				tick;
			check("results", {res_grade_o, volt_grade_o, route_grade_o, meas_error_o,
				verdict1_valid_o, verdict1_pass_o, verdict2_valid_o, verdict2_pass_o}, e);
		end
	endtask
	// =====================================================
	// main sequence
	initial
	begin
		repeat (10) @(negedge core_clk_i);
		check("reset outputs", {busy_o, res_grade_o, route_grade_o, verdict1_valid_o}, 6'h20);
		rst_i = 1'b0;
		set_lim(2'h0, 32'h64, 32'h32, 1'b1);
		set_lim(2'h1, 32'h14, 32'ha, 1'b1);
		set_lim(2'h2, 32'h32, 32'h14, 1'b1);
		set_lim(2'h0, 32'h28, 32'h3c, 1'b0);
		set_lim(2'h2, 32'h1f5, 32'h0, 1'b0);
		set_lim(2'h2, 32'h32, 32'hffffff9b, 1'b0);
		set_lim(2'h3, 32'h1, 32'h0, 1'b0);
		meas(4'hc, 32'h64, 2'h0, 32'ha, 2'h0, 16'ha, 8'h0, {6'h29, 5'h0f});
		meas(4'hc, 32'h32, 2'h0, 32'h14, 2'h0, 16'h14, 8'h0, {6'h2a, 5'h0f});
		meas(4'hc, 32'h65, 2'h0, 32'h9, 2'h0, 16'h32, 8'h0, {6'h1e, 5'h0a});
		check("terminal grades", route_term_grade_o, 8'h56);
		meas(4'hc, 32'h31, 2'h0, 32'h15, 2'h0, 16'h33, 8'h0, {6'h03, 5'h1a});
		meas(4'hc, 32'h0, 2'h1, 32'h0, 2'h2, 16'ha, 8'h4, {6'h1c, 5'h0a});
		meas(4'hc, 32'h0, 2'h3, 32'hfffffff1, 2'h0, 16'ha, 8'h0, {6'h0d, 5'h0a});
		meas(4'he, 32'h4b, 2'h0, 32'hfffffff1, 2'h0, 16'ha, 8'h0, {6'h29, 5'h0f});
		meas(4'h0, 32'h4b, 2'h0, 32'hf, 2'h0, 16'ha, 8'h0, 11'h0);
		meas(4'h8, 32'h4b, 2'h0, 32'hf, 2'h0, 16'ha, 8'h0, {6'h28, 5'h0c});
		set_lim(2'h2, 32'h1f4, 32'hffffff9c, 1'b1);
		set_lim(2'h2, 32'h96, 32'h78, 1'b1);
		meas(4'hd, 32'h4b, 2'h0, 32'hf, 2'h0, 16'h12c, 8'h0, {6'h29, 5'h0f});
		res_func_i = 1'b0;
		meas(4'hc, 32'h4b, 2'h0, 32'hf, 2'h0, 16'h12c, 8'h0, {6'h0b, 5'h0f});
		res_func_i = 1'b1;
		volt_func_i = 1'b0;
		meas(4'hc, 32'h4b, 2'h0, 32'hf, 2'h0, 16'ha, 8'h0, {6'h21, 5'h0f});
		give_verdict;
	end
endmodule
